// ===== include/tx_cfg_status_defines.vh
// register offsets, field positions and reset values for the transmit
// configuration and receive status register slice; definitions only
`ifndef TX_CFG_STATUS_DEFINES_VH
`define TX_CFG_STATUS_DEFINES_VH

// address width of the register port
`define ADDR_W 20
`define DATA_W 8

// read-clear status registers, except the write-one-clear interrupt status
`define A_RX_PARITY_ERR_CNT 20'h3_090A
`define A_STAT_FRAMING_ERR_CNT 20'h3_090B
`define A_RX_OVF_BANK0 20'h3_090C
`define A_RX_OVF_BANK1 20'h3_090D
`define A_RX_OVF_BANK2 20'h3_090E
`define A_RX_OVF_BANK3 20'h3_090F
`define A_RX_UNF_BANK0 20'h3_0918
`define A_RX_UNF_BANK1 20'h3_0919
`define A_RX_UNF_BANK2 20'h3_091A
`define A_RX_UNF_BANK3 20'h3_091B
`define A_CORE_EVENT_FLAGS 20'h3_091C
`define A_TX_BANK_FLAGS 20'h3_0950
`define A_IRQ_STATUS 20'h3_0951

// read/write configuration registers
`define A_STARVING_UPPER 20'h3_0931
`define A_STARVING_LOWER 20'h3_0932
`define A_HUNGRY_UPPER 20'h3_0933
`define A_HUNGRY_LOWER 20'h3_0934
`define A_TRAIN_INT_B3 20'h3_0935
`define A_TRAIN_INT_B2 20'h3_0936
`define A_TRAIN_INT_B1 20'h3_0937
`define A_TRAIN_INT_B0 20'h3_0940
`define A_TRAIN_REP_UPPER 20'h3_0941
`define A_TRAIN_REP_LOWER 20'h3_0942
`define A_TX_BANK_FAULT_EN 20'h3_0943
`define A_STATUS_ALIGN_TH 20'h3_0944
`define A_TX_FIFO_WMARKS 20'h3_0945
`define A_RX_BANK_FAULT_EN 20'h3_0912
`define A_CORE_EVENT_EN 20'h3_0913
`define A_IRQ_MASK 20'h3_0952

// configuration array indices
`define CFG_N 16
`define CFG_IDX_W 4
`define I_STARVING_UPPER 4'h0
`define I_STARVING_LOWER 4'h1
`define I_HUNGRY_UPPER 4'h2
`define I_HUNGRY_LOWER 4'h3
`define I_TRAIN_INT_B3 4'h4
`define I_TRAIN_INT_B2 4'h5
`define I_TRAIN_INT_B1 4'h6
`define I_TRAIN_INT_B0 4'h7
`define I_TRAIN_REP_UPPER 4'h8
`define I_TRAIN_REP_LOWER 4'h9
`define I_TX_BANK_FAULT_EN 4'hA
`define I_STATUS_ALIGN_TH 4'hB
`define I_TX_FIFO_WMARKS 4'hC
`define I_RX_BANK_FAULT_EN 4'hD
`define I_CORE_EVENT_EN 4'hE
`define I_IRQ_MASK 4'hF

// writable bit masks; all other bits are reserved and read as zero
`define M_FULL 8'hFF
`define M_UPPER2 8'h03
`define M_ALIGN_TH 8'h07
`define M_CORE_EVENT_EN 8'h01
`define M_IRQ_MASK 8'h7F
`define RESET_BYTE 8'h00

// field positions (bit 0 is the least significant bit)
`define F_UPPER2 1:0
`define F_ALIGN_TH 2:0
`define F_LOW_WMARK 7:5
`define F_HIGH_WMARK 4:0
`define F_OVF_EN_MSB 7
`define F_UNF_EN_MSB 3
`define F_FRAME_LOSS 0

// banks and fifos
`define BANKS 4
`define FIFOS_PER_BANK 8
`define RX_FLAGS_W 32

// counters
`define CNT_MAX 8'hFF
`define CNT_ONE 8'h01
`define CNT_ZERO 8'h00
`define ALIGN_CNT_W 3
`define ALIGN_TH_MIN 3'h1

// interrupt status bits
`define IRQ_W 7
`define IRQ_PARITY_ERR 0
`define IRQ_FRAMING_ERR 1
`define IRQ_RX_OVF 2
`define IRQ_RX_UNF 3
`define IRQ_TX_OVF 4
`define IRQ_TX_UNF 5
`define IRQ_FRAME_LOSS 6

// training scheduler widths
`define TRAIN_INT_W 32
`define TRAIN_REP_W 16

`endif

// ===== hdl/training_scheduler.v
// training sequence scheduler: raises a request once per interval, repeated
// a programmed number of times; assumes the transmitter pulses sent per sequence
`timescale 1ns/1ps
`include "tx_cfg_status_defines.vh"

module training_scheduler (
  // clock and reset
  input wire clk,
  input wire rst,
  // programmed values
  input wire [`TRAIN_INT_W-1:0] interval,
  input wire [`TRAIN_REP_W-1:0] repeat_count,
  // transmitter handshake
  input wire sent,
  output wire req
);

  reg [`TRAIN_INT_W-1:0] cycle_q;
  reg [`TRAIN_INT_W-1:0] cycle_d;
  reg [`TRAIN_REP_W-1:0] remain_q;
  reg [`TRAIN_REP_W-1:0] remain_d;
  reg req_q;
  reg req_d;
  wire [`TRAIN_INT_W-1:0] cycle_inc;

  assign cycle_inc = cycle_q + {{(`TRAIN_INT_W-1){1'b0}}, 1'b1};
  assign req = req_q;

  always @* begin
    cycle_d = cycle_q;
    remain_d = remain_q;
    if (interval == {`TRAIN_INT_W{1'b0}}) begin
      // zero interval: no training is ever inserted
      cycle_d = {`TRAIN_INT_W{1'b0}};
      remain_d = {`TRAIN_REP_W{1'b0}};
    end else if (remain_q != {`TRAIN_REP_W{1'b0}}) begin
      if (sent) begin
        remain_d = remain_q - {{(`TRAIN_REP_W-1){1'b0}}, 1'b1};
      end
    end else if (cycle_inc >= interval) begin
      cycle_d = {`TRAIN_INT_W{1'b0}};
      remain_d = repeat_count;
    end else begin
      cycle_d = cycle_inc;
    end
    req_d = (remain_d != {`TRAIN_REP_W{1'b0}});
  end

  always @(posedge clk) begin
    if (rst) begin
      cycle_q <= {`TRAIN_INT_W{1'b0}};
      remain_q <= {`TRAIN_REP_W{1'b0}};
      req_q <= 1'b0;
    end else begin
      cycle_q <= cycle_d;
      remain_q <= remain_d;
      req_q <= req_d;
    end
  end

endmodule // training_scheduler

// ===== hdl/tx_cfg_status_regs.v
// transmit configuration and receive status register slice of one
// packet-interface core; assumes event inputs are one-cycle pulses on MCLK
//
// Overview of operation
// - holds a 10-bit starving-port burst limit, 2 upper plus 8 lower bits
// - holds a 10-bit hungry-port burst limit, 2 upper plus 8 lower bits
// - training interval is 32 bits from four bytes, first byte most significant
// - a zero training interval means no training sequences at all
// - training is repeated a 16-bit count per interval, first byte upper
// - per-bank enables gate transmit bank overflow flags and interrupts
// - per-bank enables gate transmit bank underflow flags and interrupts
// - 3-bit threshold of consecutive bad/good status codewords loses/regains alignment
// - 3-bit input fifo low watermark applies only in minimum-burst operation
// - 5-bit async fifo high watermark declares TX_AFIFO_FULL when the fifo level is at or above it
// - 8-bit receive parity error count saturates at 255, clears on read
// - 8-bit status framing error count holds at 255, clears on read
// - eight overflow flags per receive bank, bank-enabled, read-clear, re-set if persisting
// - eight underflow flags per receive bank, bank-enabled, read-clear, re-set if persisting
// - frame loss flag sets on alignment loss only while its enable is set
`timescale 1ns/1ps
`include "tx_cfg_status_defines.vh"

module tx_cfg_status_regs (
  // clock and reset
  input wire MCLK,
  input wire RST,
  // register port
  input wire [`ADDR_W-1:0] ADDR,
  input wire [`DATA_W-1:0] WDATA,
  input wire WR,
  input wire RD,
  output wire [`DATA_W-1:0] RDATA,
  // core events
  input wire RX_PARITY_ERR,
  input wire STAT_FRAMING_ERR,
  input wire STAT_CODEWORD_GOOD,
  input wire STAT_CODEWORD_BAD,
  input wire [`RX_FLAGS_W-1:0] RX_OVF_EVT,
  input wire [`RX_FLAGS_W-1:0] RX_UNF_EVT,
  input wire [`BANKS-1:0] TX_OVF_EVT,
  input wire [`BANKS-1:0] TX_UNF_EVT,
  // transmit data path
  input wire MIN_BURST_MODE,
  input wire [4:0] TX_AFIFO_LEVEL,
  input wire TRAIN_SENT,
  output wire TRAIN_REQ,
  output wire TX_AFIFO_FULL,
  output wire [2:0] LOW_WMARK,
  output wire [9:0] STARVING_LIMIT,
  output wire [9:0] HUNGRY_LIMIT,
  // status
  output wire STATUS_ALIGNED,
  output wire IRQ
);

  // configuration decode: {hit, index}
  function [`CFG_IDX_W:0] cfg_decode;
    input [`ADDR_W-1:0] a;
    begin
      case (a)
        `A_STARVING_UPPER: cfg_decode = {1'b1, `I_STARVING_UPPER};
        `A_STARVING_LOWER: cfg_decode = {1'b1, `I_STARVING_LOWER};
        `A_HUNGRY_UPPER: cfg_decode = {1'b1, `I_HUNGRY_UPPER};
        `A_HUNGRY_LOWER: cfg_decode = {1'b1, `I_HUNGRY_LOWER};
        `A_TRAIN_INT_B3: cfg_decode = {1'b1, `I_TRAIN_INT_B3};
        `A_TRAIN_INT_B2: cfg_decode = {1'b1, `I_TRAIN_INT_B2};
        `A_TRAIN_INT_B1: cfg_decode = {1'b1, `I_TRAIN_INT_B1};
        `A_TRAIN_INT_B0: cfg_decode = {1'b1, `I_TRAIN_INT_B0};
        `A_TRAIN_REP_UPPER: cfg_decode = {1'b1, `I_TRAIN_REP_UPPER};
        `A_TRAIN_REP_LOWER: cfg_decode = {1'b1, `I_TRAIN_REP_LOWER};
        `A_TX_BANK_FAULT_EN: cfg_decode = {1'b1, `I_TX_BANK_FAULT_EN};
        `A_STATUS_ALIGN_TH: cfg_decode = {1'b1, `I_STATUS_ALIGN_TH};
        `A_TX_FIFO_WMARKS: cfg_decode = {1'b1, `I_TX_FIFO_WMARKS};
        `A_RX_BANK_FAULT_EN: cfg_decode = {1'b1, `I_RX_BANK_FAULT_EN};
        `A_CORE_EVENT_EN: cfg_decode = {1'b1, `I_CORE_EVENT_EN};
        `A_IRQ_MASK: cfg_decode = {1'b1, `I_IRQ_MASK};
        default: cfg_decode = {1'b0, `I_STARVING_UPPER};
      endcase
    end
  endfunction

  // writable bits of each configuration register
  function [`DATA_W-1:0] cfg_mask;
    input [`CFG_IDX_W-1:0] i;
    begin
      case (i)
        `I_STARVING_UPPER: cfg_mask = `M_UPPER2;
        `I_HUNGRY_UPPER: cfg_mask = `M_UPPER2;
        `I_STATUS_ALIGN_TH: cfg_mask = `M_ALIGN_TH;
        `I_CORE_EVENT_EN: cfg_mask = `M_CORE_EVENT_EN;
        `I_IRQ_MASK: cfg_mask = `M_IRQ_MASK;
        default: cfg_mask = `M_FULL;
      endcase
    end
  endfunction

  // saturating count step with read clear; an event in the read cycle is kept
  function [`DATA_W-1:0] count_next;
    input [`DATA_W-1:0] cnt;
    input ev;
    input clr;
    begin
      if (clr) begin
        count_next = ev ? `CNT_ONE : `CNT_ZERO;
      end else if (ev && cnt != `CNT_MAX) begin
        count_next = cnt + `CNT_ONE;
      end else begin
        count_next = cnt;
      end
    end
  endfunction

  reg [`DATA_W-1:0] cfg_q [0:`CFG_N-1];
  reg [`DATA_W-1:0] cnt_q [0:1];
  reg [`RX_FLAGS_W-1:0] rx_ovf_q;
  reg [`RX_FLAGS_W-1:0] rx_unf_q;
  reg [`DATA_W-1:0] tx_flags_q;
  reg frame_loss_q;
  reg [`IRQ_W-1:0] irq_stat_q;
  reg [`IRQ_W-1:0] irq_stat_d;
  reg irq_q;
  reg [`DATA_W-1:0] rdata_q;
  reg [`DATA_W-1:0] rdata_d;
  reg aligned_q;
  reg aligned_d;
  reg [`ALIGN_CNT_W-1:0] bad_run_q;
  reg [`ALIGN_CNT_W-1:0] bad_run_d;
  reg [`ALIGN_CNT_W-1:0] good_run_q;
  reg [`ALIGN_CNT_W-1:0] good_run_d;
  reg loss_evt;
  reg afifo_full_q;
  reg [2:0] low_wmark_q;
  reg [`CFG_IDX_W:0] dec;
  integer k;

  wire [`BANKS-1:0] rx_ovf_en;
  wire [`BANKS-1:0] rx_unf_en;
  wire [`BANKS-1:0] tx_ovf_en;
  wire [`BANKS-1:0] tx_unf_en;
  wire [`RX_FLAGS_W-1:0] rx_ovf_set;
  wire [`RX_FLAGS_W-1:0] rx_unf_set;
  wire [`RX_FLAGS_W-1:0] rx_ovf_clr;
  wire [`RX_FLAGS_W-1:0] rx_unf_clr;
  wire [`RX_FLAGS_W-1:0] rx_ovf_d;
  wire [`RX_FLAGS_W-1:0] rx_unf_d;
  wire [`DATA_W-1:0] tx_flags_set;
  wire [`DATA_W-1:0] tx_flags_d;
  wire [`ALIGN_CNT_W-1:0] align_th;
  wire frame_loss_d;
  wire rd_tx_flags;
  wire rd_core_flags;
  wire [1:0] cnt_ev;
  wire [1:0] cnt_clr;
  wire [3:0] rd_ovf_bank;
  wire [3:0] rd_unf_bank;

  // per-bank enables and flag banks
  genvar b;
  generate
    for (b = 0; b < `BANKS; b = b + 1) begin : g_bank
      assign rx_ovf_en[b] = cfg_q[`I_RX_BANK_FAULT_EN][`F_OVF_EN_MSB-b];
      assign rx_unf_en[b] = cfg_q[`I_RX_BANK_FAULT_EN][`F_UNF_EN_MSB-b];
      assign tx_ovf_en[b] = cfg_q[`I_TX_BANK_FAULT_EN][`F_OVF_EN_MSB-b];
      assign tx_unf_en[b] = cfg_q[`I_TX_BANK_FAULT_EN][`F_UNF_EN_MSB-b];
      assign rx_ovf_set[b*`FIFOS_PER_BANK +: `FIFOS_PER_BANK] =
        RX_OVF_EVT[b*`FIFOS_PER_BANK +: `FIFOS_PER_BANK] & {`FIFOS_PER_BANK{rx_ovf_en[b]}};
      assign rx_unf_set[b*`FIFOS_PER_BANK +: `FIFOS_PER_BANK] =
        RX_UNF_EVT[b*`FIFOS_PER_BANK +: `FIFOS_PER_BANK] & {`FIFOS_PER_BANK{rx_unf_en[b]}};
      assign rx_ovf_clr[b*`FIFOS_PER_BANK +: `FIFOS_PER_BANK] = {`FIFOS_PER_BANK{rd_ovf_bank[b]}};
      assign rx_unf_clr[b*`FIFOS_PER_BANK +: `FIFOS_PER_BANK] = {`FIFOS_PER_BANK{rd_unf_bank[b]}};
      assign tx_flags_set[`F_OVF_EN_MSB-b] = TX_OVF_EVT[b] & tx_ovf_en[b];
      assign tx_flags_set[`F_UNF_EN_MSB-b] = TX_UNF_EVT[b] & tx_unf_en[b];
    end
  endgenerate

  assign rd_ovf_bank = {RD && ADDR == `A_RX_OVF_BANK3, RD && ADDR == `A_RX_OVF_BANK2,
                        RD && ADDR == `A_RX_OVF_BANK1, RD && ADDR == `A_RX_OVF_BANK0};
  assign rd_unf_bank = {RD && ADDR == `A_RX_UNF_BANK3, RD && ADDR == `A_RX_UNF_BANK2,
                        RD && ADDR == `A_RX_UNF_BANK1, RD && ADDR == `A_RX_UNF_BANK0};
  assign rd_tx_flags = RD && ADDR == `A_TX_BANK_FLAGS;
  assign rd_core_flags = RD && ADDR == `A_CORE_EVENT_FLAGS;

  // read clears, but a set in the same cycle wins
  assign rx_ovf_d = (rx_ovf_q & ~rx_ovf_clr) | rx_ovf_set;
  assign rx_unf_d = (rx_unf_q & ~rx_unf_clr) | rx_unf_set;
  assign tx_flags_d = (tx_flags_q & ~{`DATA_W{rd_tx_flags}}) | tx_flags_set;
  assign frame_loss_d = (frame_loss_q & ~rd_core_flags) |
                        (loss_evt & cfg_q[`I_CORE_EVENT_EN][`F_FRAME_LOSS]);

  // error counters: 0 receive parity, 1 status framing
  assign cnt_ev = {STAT_FRAMING_ERR, RX_PARITY_ERR};
  assign cnt_clr = {RD && ADDR == `A_STAT_FRAMING_ERR_CNT, RD && ADDR == `A_RX_PARITY_ERR_CNT};

  // status alignment tracking; a zero threshold acts as one
  assign align_th = (cfg_q[`I_STATUS_ALIGN_TH][`F_ALIGN_TH] == {`ALIGN_CNT_W{1'b0}}) ?
                    `ALIGN_TH_MIN : cfg_q[`I_STATUS_ALIGN_TH][`F_ALIGN_TH];

  always @* begin
    aligned_d = aligned_q;
    bad_run_d = bad_run_q;
    good_run_d = good_run_q;
    loss_evt = 1'b0;
    if (STAT_CODEWORD_BAD) begin
      good_run_d = {`ALIGN_CNT_W{1'b0}};
      if (aligned_q) begin
        if ({1'b0, bad_run_q} + 4'h1 >= {1'b0, align_th}) begin
          aligned_d = 1'b0;
          loss_evt = 1'b1;
          bad_run_d = {`ALIGN_CNT_W{1'b0}};
        end else begin
          bad_run_d = bad_run_q + 3'h1;
        end
      end
    end else if (STAT_CODEWORD_GOOD) begin
      bad_run_d = {`ALIGN_CNT_W{1'b0}};
      if (!aligned_q) begin
        if ({1'b0, good_run_q} + 4'h1 >= {1'b0, align_th}) begin
          aligned_d = 1'b1;
          good_run_d = {`ALIGN_CNT_W{1'b0}};
        end else begin
          good_run_d = good_run_q + 3'h1;
        end
      end
    end
  end

  // interrupt status: write one clears, a new event wins
  always @* begin
    irq_stat_d = irq_stat_q;
    if (WR && ADDR == `A_IRQ_STATUS) begin
      irq_stat_d = irq_stat_q & ~WDATA[`IRQ_W-1:0];
    end
    irq_stat_d[`IRQ_PARITY_ERR] = irq_stat_d[`IRQ_PARITY_ERR] | RX_PARITY_ERR;
    irq_stat_d[`IRQ_FRAMING_ERR] = irq_stat_d[`IRQ_FRAMING_ERR] | STAT_FRAMING_ERR;
    irq_stat_d[`IRQ_RX_OVF] = irq_stat_d[`IRQ_RX_OVF] | (|rx_ovf_set);
    irq_stat_d[`IRQ_RX_UNF] = irq_stat_d[`IRQ_RX_UNF] | (|rx_unf_set);
    irq_stat_d[`IRQ_TX_OVF] = irq_stat_d[`IRQ_TX_OVF] | (|(TX_OVF_EVT & tx_ovf_en));
    irq_stat_d[`IRQ_TX_UNF] = irq_stat_d[`IRQ_TX_UNF] | (|(TX_UNF_EVT & tx_unf_en));
    irq_stat_d[`IRQ_FRAME_LOSS] = irq_stat_d[`IRQ_FRAME_LOSS] |
                                  (loss_evt & cfg_q[`I_CORE_EVENT_EN][`F_FRAME_LOSS]);
  end

  // read data mux; reserved bits and unmapped addresses read zero
  always @* begin
    dec = cfg_decode(ADDR);
    rdata_d = `RESET_BYTE;
    if (RD) begin
      if (dec[`CFG_IDX_W]) begin
        rdata_d = cfg_q[dec[`CFG_IDX_W-1:0]] & cfg_mask(dec[`CFG_IDX_W-1:0]);
      end else begin
        case (ADDR)
          `A_RX_PARITY_ERR_CNT: rdata_d = cnt_q[0];
          `A_STAT_FRAMING_ERR_CNT: rdata_d = cnt_q[1];
          `A_RX_OVF_BANK0: rdata_d = rx_ovf_q[7:0];
          `A_RX_OVF_BANK1: rdata_d = rx_ovf_q[15:8];
          `A_RX_OVF_BANK2: rdata_d = rx_ovf_q[23:16];
          `A_RX_OVF_BANK3: rdata_d = rx_ovf_q[31:24];
          `A_RX_UNF_BANK0: rdata_d = rx_unf_q[7:0];
          `A_RX_UNF_BANK1: rdata_d = rx_unf_q[15:8];
          `A_RX_UNF_BANK2: rdata_d = rx_unf_q[23:16];
          `A_RX_UNF_BANK3: rdata_d = rx_unf_q[31:24];
          `A_CORE_EVENT_FLAGS: rdata_d = {7'h00, frame_loss_q};
          `A_TX_BANK_FLAGS: rdata_d = tx_flags_q;
          `A_IRQ_STATUS: rdata_d = {1'b0, irq_stat_q};
          default: rdata_d = `RESET_BYTE;
        endcase
      end
    end
  end

  always @(posedge MCLK) begin
    if (RST) begin
      for (k = 0; k < `CFG_N; k = k + 1) begin
        cfg_q[k] <= `RESET_BYTE;
      end
      cnt_q[0] <= `CNT_ZERO;
      cnt_q[1] <= `CNT_ZERO;
      rx_ovf_q <= {`RX_FLAGS_W{1'b0}};
      rx_unf_q <= {`RX_FLAGS_W{1'b0}};
      tx_flags_q <= `RESET_BYTE;
      frame_loss_q <= 1'b0;
      irq_stat_q <= {`IRQ_W{1'b0}};
      irq_q <= 1'b0;
      rdata_q <= `RESET_BYTE;
      aligned_q <= 1'b0;
      bad_run_q <= {`ALIGN_CNT_W{1'b0}};
      good_run_q <= {`ALIGN_CNT_W{1'b0}};
      afifo_full_q <= 1'b0;
      low_wmark_q <= 3'h0;
    end else begin
      if (WR && dec[`CFG_IDX_W]) begin
        cfg_q[dec[`CFG_IDX_W-1:0]] <= WDATA & cfg_mask(dec[`CFG_IDX_W-1:0]);
      end
      cnt_q[0] <= count_next(cnt_q[0], cnt_ev[0], cnt_clr[0]);
      cnt_q[1] <= count_next(cnt_q[1], cnt_ev[1], cnt_clr[1]);
      rx_ovf_q <= rx_ovf_d;
      rx_unf_q <= rx_unf_d;
      tx_flags_q <= tx_flags_d;
      frame_loss_q <= frame_loss_d;
      irq_stat_q <= irq_stat_d;
      irq_q <= |(irq_stat_d & cfg_q[`I_IRQ_MASK][`IRQ_W-1:0]);
      rdata_q <= rdata_d;
      aligned_q <= aligned_d;
      bad_run_q <= bad_run_d;
      good_run_q <= good_run_d;
      afifo_full_q <= TX_AFIFO_LEVEL >= cfg_q[`I_TX_FIFO_WMARKS][`F_HIGH_WMARK];
      low_wmark_q <= MIN_BURST_MODE ? cfg_q[`I_TX_FIFO_WMARKS][`F_LOW_WMARK] : 3'h0;
    end
  end

  // training sequence insertion
  training_scheduler u_train (
    .clk(MCLK),
    .rst(RST),
    .interval({cfg_q[`I_TRAIN_INT_B3], cfg_q[`I_TRAIN_INT_B2],
               cfg_q[`I_TRAIN_INT_B1], cfg_q[`I_TRAIN_INT_B0]}),
    .repeat_count({cfg_q[`I_TRAIN_REP_UPPER], cfg_q[`I_TRAIN_REP_LOWER]}),
    .sent(TRAIN_SENT),
    .req(TRAIN_REQ)
  );

  // outputs
  assign STARVING_LIMIT = {cfg_q[`I_STARVING_UPPER][`F_UPPER2], cfg_q[`I_STARVING_LOWER]};
  assign HUNGRY_LIMIT = {cfg_q[`I_HUNGRY_UPPER][`F_UPPER2], cfg_q[`I_HUNGRY_LOWER]};
  assign TX_AFIFO_FULL = afifo_full_q;
  assign LOW_WMARK = low_wmark_q;
  assign STATUS_ALIGNED = aligned_q;
  assign IRQ = irq_q;
  assign RDATA = rdata_q;

endmodule // tx_cfg_status_regs

// ===== sim/tx_cfg_status_regs_asserts.sv
// assertions on the top-level ports of the register slice
// assumes one MCLK domain and the synchronous reset RST
`timescale 1ns/1ps
`include "tx_cfg_status_defines.vh"
module tx_cfg_status_regs_chk (
  // clock and reset
  input wire MCLK,
  input wire RST,
  // register port
  input wire [`ADDR_W-1:0] ADDR,
  input wire [`DATA_W-1:0] WDATA,
  input wire WR,
  input wire RD,
  input wire [`DATA_W-1:0] RDATA,
  // events
  input wire RX_PARITY_ERR,
  input wire STAT_FRAMING_ERR,
  input wire STAT_CODEWORD_GOOD,
  input wire STAT_CODEWORD_BAD,
  input wire MIN_BURST_MODE,
  input wire [4:0] TX_AFIFO_LEVEL,
  // outputs
  input wire TX_AFIFO_FULL,
  input wire [2:0] LOW_WMARK,
  input wire [9:0] STARVING_LIMIT,
  input wire [9:0] HUNGRY_LIMIT,
  input wire STATUS_ALIGNED
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  // a counter read in a cycle without a new error
  sequence quiet_read(a, ev);
    RD && ADDR == a && !ev;
  endsequence
  a_starv_lower: assert property (
    WR && ADDR == `A_STARVING_LOWER |=> STARVING_LIMIT[7:0] == $past(WDATA))
    else $error("starving lower byte not applied");
  a_hungry_upper: assert property (
    WR && ADDR == `A_HUNGRY_UPPER |=> HUNGRY_LIMIT[9:8] == $past(WDATA[1:0]))
    else $error("hungry upper bits not applied");
  a_full_at_top: assert property (
    $past(TX_AFIFO_LEVEL) == 5'h1F && !$past(RST) |-> TX_AFIFO_FULL)
    else $error("full level not flagged");
  a_wmark_gated: assert property (
    !$past(MIN_BURST_MODE) |-> LOW_WMARK == 3'h0)
    else $error("low watermark shown outside minimum burst");
  a_parity_clear: assert property (
    quiet_read(`A_RX_PARITY_ERR_CNT, RX_PARITY_ERR) ##1
    quiet_read(`A_RX_PARITY_ERR_CNT, RX_PARITY_ERR) |=> RDATA == 8'h00)
    else $error("parity count not cleared by read");
  a_framing_clear: assert property (
    quiet_read(`A_STAT_FRAMING_ERR_CNT, STAT_FRAMING_ERR) ##1
    quiet_read(`A_STAT_FRAMING_ERR_CNT, STAT_FRAMING_ERR) |=> RDATA == 8'h00)
    else $error("framing count not cleared by read");
  a_align_gain: assert property (
    $rose(STATUS_ALIGNED) |-> $past(STAT_CODEWORD_GOOD) && !$past(STAT_CODEWORD_BAD))
    else $error("alignment gained without a good codeword");
  a_align_loss: assert property (
    $fell(STATUS_ALIGNED) && !$past(RST) |-> $past(STAT_CODEWORD_BAD))
    else $error("alignment lost without a bad codeword");
  a_unmapped_zero: assert property (
    RD && ADDR == 20'h3_0946 |=> RDATA == 8'h00)
    else $error("unmapped address read nonzero");
endmodule // tx_cfg_status_regs_chk

bind tx_cfg_status_regs tx_cfg_status_regs_chk chk_u (.MCLK(MCLK), .RST(RST),
  .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .RX_PARITY_ERR(RX_PARITY_ERR), .STAT_FRAMING_ERR(STAT_FRAMING_ERR),
  .STAT_CODEWORD_GOOD(STAT_CODEWORD_GOOD), .STAT_CODEWORD_BAD(STAT_CODEWORD_BAD),
  .MIN_BURST_MODE(MIN_BURST_MODE), .TX_AFIFO_LEVEL(TX_AFIFO_LEVEL),
  .TX_AFIFO_FULL(TX_AFIFO_FULL), .LOW_WMARK(LOW_WMARK),
  .STARVING_LIMIT(STARVING_LIMIT), .HUNGRY_LIMIT(HUNGRY_LIMIT),
  .STATUS_ALIGNED(STATUS_ALIGNED));

// ===== sim/tb.sv
// self-checking bench for the register slice, one instance on a 100 MHz clock
// assumes the defines header is on the include path
`timescale 1ns/1ps
`include "tx_cfg_status_defines.vh"
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [19:0] addr = 20'h0_0000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd_s = 1'b0;
  logic [4:0] ev = 5'h00;
  logic [31:0] ovf = 32'h0000_0000;
  logic [31:0] unf = 32'h0000_0000;
  logic [3:0] tovf = 4'h0;
  logic [3:0] tunf = 4'h0;
  logic mb = 1'b0;
  logic [4:0] lvl = 5'h00;
  wire [7:0] rdata;
  wire train_req, full, aligned, irq;
  wire [2:0] lwm;
  wire [9:0] starv, hung;
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0;
  // address, write value, read-back value
  logic [35:0] rows [11] = '{36'h3_0931_FF03, 36'h3_0932_A5A5, 36'h3_0933_FE02,
    36'h3_0934_5A5A, 36'h3_0941_1212, 36'h3_0942_3434, 36'h3_0943_C3C3,
    36'h3_0944_FF07, 36'h3_0945_E8E8, 36'h3_0946_FF00, 36'h3_0908_FF00};

  tx_cfg_status_regs dut_u (.MCLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd_s), .RDATA(rdata), .RX_PARITY_ERR(ev[0]), .STAT_FRAMING_ERR(ev[1]),
    .STAT_CODEWORD_GOOD(ev[2]), .STAT_CODEWORD_BAD(ev[3]), .RX_OVF_EVT(ovf),
    .RX_UNF_EVT(unf), .TX_OVF_EVT(tovf), .TX_UNF_EVT(tunf), .MIN_BURST_MODE(mb),
    .TX_AFIFO_LEVEL(lvl), .TRAIN_SENT(ev[4]), .TRAIN_REQ(train_req), .TX_AFIFO_FULL(full),
    .LOW_WMARK(lwm), .STARVING_LIMIT(starv), .HUNGRY_LIMIT(hung),
    .STATUS_ALIGNED(aligned), .IRQ(irq));

  initial begin
    forever #5 clk = ~clk;
  end

  task close_out;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      close_out;
    end
  end

  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task wr_reg(input logic [19:0] a, input logic [7:0] v);
    @(posedge clk) begin
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
    end
    @(posedge clk) wr <= 1'b0;
  endtask

  // two back-to-back reads of one address
  task rd_reg(input logic [19:0] a, output logic [7:0] d, output logic [7:0] e);
    @(posedge clk) begin
      rd_s <= 1'b1;
      addr <= a;
    end
    @(posedge clk);
    #1 d = rdata;
    @(posedge clk) rd_s <= 1'b0;
    #1 e = rdata;
  endtask

  task pulse(input logic [4:0] m, input int n);
    repeat (n) begin
      @(posedge clk) ev <= m;
      @(posedge clk) ev <= 5'h00;
    end
  endtask

  task idle_req(input int n);
    int k;
    k = 0;
    repeat (n) begin
      @(posedge clk);
      #1 k += int'(train_req === 1'b1);
    end
    chk(16'(k), 16'h0000);
  endtask

  initial begin
    logic [7:0] d, e;
    int n;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 11; i++) begin
      rd_reg(rows[i][35:16], d, e);
      chk(16'(d), 16'h0000);
      wr_reg(rows[i][35:16], rows[i][15:8]);
      rd_reg(rows[i][35:16], d, e);
      chk(16'(d), 16'(rows[i][7:0]));
    end
    chk(16'(starv), 16'h03A5);
    chk(16'(hung), 16'h025A);
    // watermarks
    @(posedge clk) lvl <= 5'h07;
    repeat (2) @(posedge clk);
    #1 chk(16'({lwm, full}), 16'h0000);
    @(posedge clk) begin
      mb <= 1'b1;
      lvl <= 5'h08;
    end
    repeat (2) @(posedge clk);
    #1 chk(16'({lwm, full}), 16'h000F);
    @(posedge clk) lvl <= 5'h1F;
    repeat (2) @(posedge clk);
    #1 chk(16'(full), 16'h0001);
    // counters and interrupts
    pulse(5'h01, 300);
    pulse(5'h02, 3);
    rd_reg(`A_RX_PARITY_ERR_CNT, d, e);
    chk(16'({d, e}), 16'hFF00);
    rd_reg(`A_STAT_FRAMING_ERR_CNT, d, e);
    chk(16'({d, e}), 16'h0300);
    rd_reg(`A_IRQ_STATUS, d, e);
    chk(16'({d, irq}), 16'h0006);
    wr_reg(`A_IRQ_MASK, 8'h02);
    repeat (2) @(posedge clk);
    #1 chk(16'(irq), 16'h0001);
    wr_reg(`A_IRQ_STATUS, 8'h03);
    rd_reg(`A_IRQ_STATUS, d, e);
    chk(16'({d, irq}), 16'h0000);
    // receive bank flags
    wr_reg(`A_RX_BANK_FAULT_EN, 8'h88);
    @(posedge clk) begin
      ovf <= 32'h0000_0101;
      unf <= 32'h0000_0008;
    end
    rd_reg(`A_RX_OVF_BANK0, d, e);
    chk(16'({d, e}), 16'h0101);
    rd_reg(`A_RX_OVF_BANK1, d, e);
    chk(16'({d, e}), 16'h0000);
    @(posedge clk) begin
      ovf <= 32'h0000_0000;
      unf <= 32'h0000_0000;
    end
    rd_reg(`A_RX_OVF_BANK0, d, e);
    chk(16'({d, e}), 16'h0100);
    rd_reg(`A_RX_UNF_BANK0, d, e);
    chk(16'({d, e}), 16'h0800);
    // transmit bank flags
    @(posedge clk) begin
      tovf <= 4'hF;
      tunf <= 4'hF;
    end
    @(posedge clk) begin
      tovf <= 4'h0;
      tunf <= 4'h0;
    end
    rd_reg(`A_TX_BANK_FLAGS, d, e);
    chk(16'(d), 16'h00C3);
    // alignment and frame loss
    wr_reg(`A_IRQ_STATUS, 8'h7F);
    wr_reg(`A_IRQ_MASK, 8'h40);
    wr_reg(`A_CORE_EVENT_EN, 8'h01);
    pulse(5'h04, 6);
    #1 chk(16'(aligned), 16'h0000);
    pulse(5'h04, 1);
    #1 chk(16'({aligned, irq}), 16'h0002);
    pulse(5'h08, 6);
    #1 chk(16'(aligned), 16'h0001);
    pulse(5'h08, 1);
    @(posedge clk);
    #1 chk(16'({aligned, irq}), 16'h0001);
    rd_reg(`A_CORE_EVENT_FLAGS, d, e);
    chk(16'(d), 16'h0001);
    // training
    idle_req(40);
    wr_reg(`A_TRAIN_INT_B3, 8'h01);
    idle_req(40);
    wr_reg(`A_TRAIN_INT_B3, 8'h00);
    wr_reg(`A_TRAIN_REP_UPPER, 8'h00);
    wr_reg(`A_TRAIN_REP_LOWER, 8'h02);
    wr_reg(`A_TRAIN_INT_B0, 8'h10);
    n = 0;
    while (train_req !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1 n++;
    end
    chk(16'(n), 16'h0010);
    pulse(5'h10, 1);
    #1 chk(16'(train_req), 16'h0001);
    pulse(5'h10, 1);
    @(posedge clk);
    #1 chk(16'(train_req), 16'h0000);
    // reset in mid-run
    @(posedge clk) rst <= 1'b1;
    @(posedge clk) rst <= 1'b0;
    #1 chk(16'({starv, full, irq, aligned, train_req}), 16'h0000);
    chk(16'({hung, lwm}), 16'h0000);
    rd_reg(`A_STARVING_LOWER, d, e);
    chk(16'(d), 16'h0000);
    close_out;
  end
endmodule // tb
